// ===== pdw_cfg.svh
// Constants for the PCI target DMA window and translation block
`ifndef PDW_CFG_SVH
`define PDW_CFG_SVH

// ----------------------------------------------------------------------
// Window decode
// ----------------------------------------------------------------------
`define PDW_NUM_WIN 6
`define PDW_MIN_SHIFT 5'd8
`define PDW_SIZE_MAX 5'd22
`define PDW_SIZE_W 5

// ----------------------------------------------------------------------
// Translation buffer
// ----------------------------------------------------------------------
`define PDW_TLB_ENTRIES 16
`define PDW_TLB_IDX_W 4
`define PDW_PAGE_SHIFT 12
`define PDW_TAG_W 20
`define PDW_PHYS_W 16
`define PDW_MEM_ADDR_W 28

// ----------------------------------------------------------------------
// Interrupt level raised on a translation miss
// ----------------------------------------------------------------------
`define PDW_MISS_LEVEL 4'hF
`define PDW_NO_LEVEL 4'h0

// ----------------------------------------------------------------------
// Bus commands
// ----------------------------------------------------------------------
`define PDW_CMD_IO_RD 4'h2
`define PDW_CMD_IO_WR 4'h3
`define PDW_CMD_MEM_RD 4'h6
`define PDW_CMD_MEM_WR 4'h7
`define PDW_CMD_MEM_RD_MULT 4'hC
`define PDW_CMD_MEM_RD_LINE 4'hE
`define PDW_CMD_MEM_WR_INV 4'hF

`endif

// ===== pdw_pkg.sv
// Types shared by the PCI target DMA window and translation block
package pdw_pkg;

  // ----------------------------------------------------------------------
  // Target state, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    PDW_IDLE = 4'h1,
    PDW_DATA = 4'h2,
    PDW_MEM = 4'h4,
    PDW_RDW = 4'h8
  } pdw_state_type;

endpackage : pdw_pkg

// ===== pdw_xlate_buf.sv
// Translation buffer: tagged entries with direct access and single flush
`timescale 1ns/1ps
`default_nettype none
`include "pdw_cfg.svh"

module pdw_xlate_buf #(
  parameter int ENTRIES = `PDW_TLB_ENTRIES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Direct access
  input wire logic acc_wr,
  input wire logic acc_inval,
  input wire logic [`PDW_TLB_IDX_W-1:0] acc_idx,
  input wire logic [`PDW_TAG_W-1:0] acc_tag,
  input wire logic [`PDW_PHYS_W-1:0] acc_data,
  input wire logic acc_valid,
  output logic [`PDW_TAG_W-1:0] rd_tag,
  output logic [`PDW_PHYS_W-1:0] rd_data,
  output logic rd_valid,
  // Lookup
  input wire logic [`PDW_TAG_W-1:0] lu_page,
  output logic lu_hit,
  output logic [`PDW_PHYS_W-1:0] lu_phys
);

  logic [`PDW_TAG_W-1:0] tag_r [ENTRIES];
  logic [`PDW_TAG_W-1:0] tag_nxt [ENTRIES];
  logic [`PDW_PHYS_W-1:0] phys_r [ENTRIES];
  logic [`PDW_PHYS_W-1:0] phys_nxt [ENTRIES];
  logic [ENTRIES-1:0] vld_r;
  logic [ENTRIES-1:0] vld_nxt;
  logic [ENTRIES-1:0] match;
  logic [`PDW_TAG_W-1:0] rd_tag_r;
  logic [`PDW_PHYS_W-1:0] rd_data_r;
  logic rd_valid_r;

  // ----------------------------------------------------------------------
  // Entry storage and access
  // ----------------------------------------------------------------------

  // Every entry is compared, so all of them take part in translation
  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : g_ent
      assign match[gi] = vld_r[gi] && (tag_r[gi] == lu_page);
      always_comb begin
        tag_nxt[gi] = tag_r[gi];
        phys_nxt[gi] = phys_r[gi];
        vld_nxt[gi] = vld_r[gi];
        if (acc_wr && (int'(acc_idx) == gi)) begin
          tag_nxt[gi] = acc_tag;
          phys_nxt[gi] = acc_data;
          vld_nxt[gi] = acc_valid;
        end
        // Flush of one line only; a flush beats a write to the same line
        if (acc_inval && (int'(acc_idx) == gi)) begin
          vld_nxt[gi] = 1'b0;
        end
      end
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          tag_r[gi] <= '0;
          phys_r[gi] <= '0;
          vld_r[gi] <= 1'b0;
        end else begin
          tag_r[gi] <= tag_nxt[gi];
          phys_r[gi] <= phys_nxt[gi];
          vld_r[gi] <= vld_nxt[gi];
        end
      end
    end
  endgenerate

  // Lowest matching index wins if software loaded duplicate tags
  always_comb begin
    lu_hit = 1'b0;
    lu_phys = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (match[i]) begin
        lu_hit = 1'b1;
        lu_phys = phys_r[i];
      end
    end
  end

  // Read-back port registers the addressed entry
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_tag_r <= '0;
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_tag_r <= tag_r[acc_idx];
      rd_data_r <= phys_r[acc_idx];
      rd_valid_r <= vld_r[acc_idx];
    end
  end
  assign rd_tag = rd_tag_r;
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_flush_one_line: assert property (
    acc_inval && !acc_wr |=> !vld_r[$past(acc_idx)] &&
      ((vld_r | (ENTRIES'(1) << $past(acc_idx))) ==
       ($past(vld_r) | (ENTRIES'(1) << $past(acc_idx)))))
    else $error("flush disturbed another entry");

  a_write_readback: assert property (
    acc_wr ##1 (acc_idx == $past(acc_idx)) |=> rd_tag == $past(acc_tag, 2) &&
      rd_data == $past(acc_data, 2))
    else $error("entry read-back differs from written value");

endmodule : pdw_xlate_buf
`default_nettype wire

// ===== pdw_target.sv
// PCI target DMA path: window decode, address translation, memory forwarding
`timescale 1ns/1ps
`default_nettype none
`include "pdw_cfg.svh"

// Function
// - A transaction is claimed only when its address lies in one of six base/size windows.
// - A window answers only the transaction type it is set for, I/O or memory.
// - Window size is a power of two from 256 bytes up to one gigabyte.
// - A burst that runs out of one window into the next matching window keeps going.
// - Accepted addresses are translated through a 16-entry buffer, every entry usable.
// - A translation miss signals a processor interrupt at level 15.
// - Software can write and read back the tag and data of each of the 16 entries.
// - Software can flush one translation entry without touching the others.
// - Write-and-invalidate, read-multiple and read-line commands are accepted as bursts.
// - Bursts may start or end partway through a word under the master's byte enables.
// - Addresses outside the windows are never claimed, leaving them to a master abort.
// - Byte, halfword, word, doubleword and 4- or 8-word bursts work in both window types.
module pdw_target
  import pdw_pkg::*;
#(
  parameter int NUM_WIN = `PDW_NUM_WIN,
  parameter int ENTRIES = `PDW_TLB_ENTRIES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Window setup
  input wire logic [31:0] target_window_base [NUM_WIN],
  input wire logic [`PDW_SIZE_W-1:0] target_window_size [NUM_WIN],
  input wire logic [NUM_WIN-1:0] win_enable,
  input wire logic [NUM_WIN-1:0] win_is_io,
  // Translation buffer direct access
  input wire logic tlb_acc_wr,
  input wire logic tlb_acc_inval,
  input wire logic [`PDW_TLB_IDX_W-1:0] tlb_acc_idx,
  input wire logic [`PDW_TAG_W-1:0] tlb_acc_tag,
  input wire logic [`PDW_PHYS_W-1:0] tlb_acc_data,
  input wire logic tlb_acc_valid,
  output logic [`PDW_TAG_W-1:0] tlb_rd_tag,
  output logic [`PDW_PHYS_W-1:0] tlb_rd_data,
  output logic tlb_rd_valid,
  // PCI target address phase
  input wire logic pci_addr_valid,
  input wire logic [31:0] pci_addr,
  input wire logic [3:0] pci_cmd,
  output logic pci_claim,
  // PCI target data phases
  input wire logic pci_data_valid,
  input wire logic [3:0] pci_be,
  input wire logic [31:0] pci_wdata,
  input wire logic pci_last,
  output logic pci_data_ready,
  output logic [31:0] pci_rdata,
  output logic pci_rdata_valid,
  output logic pci_stop,
  output logic pci_abort,
  output logic pci_busy,
  // Internal memory bus
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic mem_req_write,
  output logic [`PDW_MEM_ADDR_W-1:0] mem_req_addr,
  output logic [3:0] mem_req_be,
  output logic [31:0] mem_req_wdata,
  input wire logic mem_rdata_valid,
  input wire logic [31:0] mem_rdata,
  // Processor interrupt
  output logic irq_miss,
  output logic [3:0] irq_level
);
  import pdw_pkg::*;

  // ----------------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------------

  // Size code n selects 256 << n bytes; codes past 1 GB never match
  function automatic logic win_match(input logic [31:0] a, input logic [31:0] b,
                                     input logic [`PDW_SIZE_W-1:0] sz);
    logic [31:0] mask;
    mask = 32'hFFFFFFFF << (sz + `PDW_MIN_SHIFT);
    return (sz <= `PDW_SIZE_MAX) && (((a ^ b) & mask) == 32'h0);
  endfunction : win_match

  logic new_is_io;
  logic new_is_mem;
  logic [NUM_WIN-1:0] new_win_hit;
  logic [NUM_WIN-1:0] cur_win_hit;
  logic new_hit;
  logic cur_hit;
  pdw_state_type state_r;
  pdw_state_type state_nxt;
  logic [31:0] cur_addr_r;
  logic [31:0] cur_addr_nxt;
  logic cur_io_r;
  logic cur_io_nxt;
  logic cur_wr_r;
  logic cur_wr_nxt;
  logic last_r;
  logic last_nxt;
  logic tlb_hit;
  logic [`PDW_PHYS_W-1:0] tlb_phys;

  // Only the commands a target should answer are decoded
  always_comb begin
    new_is_io = (pci_cmd == `PDW_CMD_IO_RD) || (pci_cmd == `PDW_CMD_IO_WR);
    new_is_mem = (pci_cmd == `PDW_CMD_MEM_RD) || (pci_cmd == `PDW_CMD_MEM_WR) ||
                 (pci_cmd == `PDW_CMD_MEM_RD_MULT) || (pci_cmd == `PDW_CMD_MEM_RD_LINE) ||
                 (pci_cmd == `PDW_CMD_MEM_WR_INV);
  end

  // Each window checks both the new address and the running burst address
  genvar gw;
  generate
    for (gw = 0; gw < NUM_WIN; gw++) begin : g_win
      assign new_win_hit[gw] = win_enable[gw] &&
        win_match(pci_addr, target_window_base[gw], target_window_size[gw]) &&
        (win_is_io[gw] ? new_is_io : new_is_mem);
      assign cur_win_hit[gw] = win_enable[gw] &&
        win_match(cur_addr_r, target_window_base[gw], target_window_size[gw]) &&
        (win_is_io[gw] == cur_io_r);
    end
  endgenerate
  assign new_hit = |new_win_hit;
  assign cur_hit = |cur_win_hit;

  // ----------------------------------------------------------------------
  // Translation buffer
  // ----------------------------------------------------------------------
  pdw_xlate_buf #(
    .ENTRIES(ENTRIES)
  ) u_xlate (
    .clock(clock),
    .sys_rst(sys_rst),
    .acc_wr(tlb_acc_wr),
    .acc_inval(tlb_acc_inval),
    .acc_idx(tlb_acc_idx),
    .acc_tag(tlb_acc_tag),
    .acc_data(tlb_acc_data),
    .acc_valid(tlb_acc_valid),
    .rd_tag(tlb_rd_tag),
    .rd_data(tlb_rd_data),
    .rd_valid(tlb_rd_valid),
    .lu_page(cur_addr_r[31:`PDW_PAGE_SHIFT]),
    .lu_hit(tlb_hit),
    .lu_phys(tlb_phys)
  );

  // ----------------------------------------------------------------------
  // Target sequencing
  // ----------------------------------------------------------------------
  logic claim_r;
  logic claim_nxt;
  logic stop_r;
  logic stop_nxt;
  logic abort_r;
  logic abort_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [3:0] irq_level_r;
  logic [3:0] irq_level_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [`PDW_MEM_ADDR_W-1:0] maddr_r;
  logic [`PDW_MEM_ADDR_W-1:0] maddr_nxt;
  logic [3:0] mbe_r;
  logic [3:0] mbe_nxt;
  logic [31:0] mwdata_r;
  logic [31:0] mwdata_nxt;
  logic [31:0] next_word;
  logic phase_ok;

  // A phase proceeds only while the burst address is still decoded and mapped
  assign phase_ok = cur_hit && tlb_hit;
  assign next_word = {cur_addr_r[31:2], 2'b00} + 32'h4;

  // Next values for the target state and its pulses
  always_comb begin
    state_nxt = state_r;
    cur_addr_nxt = cur_addr_r;
    cur_io_nxt = cur_io_r;
    cur_wr_nxt = cur_wr_r;
    last_nxt = last_r;
    claim_nxt = 1'b0;
    stop_nxt = 1'b0;
    abort_nxt = 1'b0;
    irq_nxt = 1'b0;
    irq_level_nxt = irq_level_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    maddr_nxt = maddr_r;
    mbe_nxt = mbe_r;
    mwdata_nxt = mwdata_r;
    case (state_r)
      PDW_IDLE: begin
        // Unclaimed addresses are simply ignored, so the master aborts
        if (pci_addr_valid && new_hit) begin
          claim_nxt = 1'b1;
          cur_addr_nxt = pci_addr;
          cur_io_nxt = new_is_io;
          cur_wr_nxt = pci_cmd[0];
          state_nxt = PDW_DATA;
        end
      end
      PDW_DATA: begin
        if (pci_data_valid) begin
          if (!cur_hit) begin
            // Ran off every window of this type: disconnect
            stop_nxt = 1'b1;
            state_nxt = PDW_IDLE;
          end else if (!tlb_hit) begin
            // The miss level stays up until the next good phase
            irq_nxt = 1'b1;
            irq_level_nxt = `PDW_MISS_LEVEL;
            abort_nxt = 1'b1;
            state_nxt = PDW_IDLE;
          end else begin
            // Any byte-enable pattern passes through unchanged
            maddr_nxt = {tlb_phys, cur_addr_r[`PDW_PAGE_SHIFT-1:2], 2'b00};
            mbe_nxt = pci_be;
            mwdata_nxt = pci_wdata;
            last_nxt = pci_last;
            irq_level_nxt = `PDW_NO_LEVEL;
            state_nxt = PDW_MEM;
          end
        end
      end
      PDW_MEM: begin
        if (mem_req_ready) begin
          if (cur_wr_r) begin
            cur_addr_nxt = next_word;
            state_nxt = last_r ? PDW_IDLE : PDW_DATA;
          end else begin
            state_nxt = PDW_RDW;
          end
        end
      end
      PDW_RDW: begin
        if (mem_rdata_valid) begin
          rdata_nxt = mem_rdata;
          rvalid_nxt = 1'b1;
          cur_addr_nxt = next_word;
          state_nxt = last_r ? PDW_IDLE : PDW_DATA;
        end
      end
      default: begin
        state_nxt = PDW_IDLE;
      end
    endcase
  end

  // Register the target state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= PDW_IDLE;
      cur_addr_r <= 32'h0;
      cur_io_r <= 1'b0;
      cur_wr_r <= 1'b0;
      last_r <= 1'b0;
      claim_r <= 1'b0;
      stop_r <= 1'b0;
      abort_r <= 1'b0;
      irq_r <= 1'b0;
      irq_level_r <= `PDW_NO_LEVEL;
      rdata_r <= 32'h0;
      rvalid_r <= 1'b0;
      maddr_r <= '0;
      mbe_r <= 4'h0;
      mwdata_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      cur_addr_r <= cur_addr_nxt;
      cur_io_r <= cur_io_nxt;
      cur_wr_r <= cur_wr_nxt;
      last_r <= last_nxt;
      claim_r <= claim_nxt;
      stop_r <= stop_nxt;
      abort_r <= abort_nxt;
      irq_r <= irq_nxt;
      irq_level_r <= irq_level_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      maddr_r <= maddr_nxt;
      mbe_r <= mbe_nxt;
      mwdata_r <= mwdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pci_claim = claim_r;
  assign pci_stop = stop_r;
  assign pci_abort = abort_r;
  assign pci_busy = (state_r != PDW_IDLE);
  assign pci_data_ready = (state_r == PDW_DATA) && phase_ok;
  assign pci_rdata = rdata_r;
  assign pci_rdata_valid = rvalid_r;
  assign mem_req_valid = (state_r == PDW_MEM);
  assign mem_req_write = cur_wr_r;
  assign mem_req_addr = maddr_r;
  assign mem_req_be = mbe_r;
  assign mem_req_wdata = mwdata_r;
  assign irq_miss = irq_r;
  assign irq_level = irq_level_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_claim_in_window: assert property (
    (state_r == PDW_IDLE) && pci_addr_valid && new_hit |=> pci_claim ##1 !pci_claim)
    else $error("windowed address not claimed for exactly one cycle");

  a_no_claim_outside: assert property (
    pci_claim |-> $past(new_hit) && $past(pci_addr_valid))
    else $error("claimed an address outside every window");

  a_io_type_only: assert property (
    (state_r == PDW_IDLE) && pci_addr_valid && new_is_io &&
      !(|(new_win_hit & win_is_io)) |=> !pci_claim)
    else $error("I/O command claimed by a memory window");

  a_burst_crosses: assert property (
    (state_r == PDW_DATA) && pci_data_valid && phase_ok |=> !pci_stop && !pci_abort &&
      mem_req_valid)
    else $error("mapped burst phase was refused");

  a_miss_level: assert property (
    (state_r == PDW_DATA) && pci_data_valid && cur_hit && !tlb_hit |=>
      irq_miss && (irq_level == `PDW_MISS_LEVEL) ##1 !irq_miss &&
      (irq_level == `PDW_MISS_LEVEL))
    else $error("translation miss did not raise level 15");

  a_xlate_addr: assert property (
    (state_r == PDW_DATA) && pci_data_valid && phase_ok |=>
      mem_req_addr == {$past(tlb_phys), $past(cur_addr_r[`PDW_PAGE_SHIFT-1:2]), 2'b00})
    else $error("memory address not the translated page");

  a_be_forward: assert property (
    (state_r == PDW_DATA) && pci_data_valid && phase_ok |=>
      mem_req_be == $past(pci_be) && mem_req_wdata == $past(pci_wdata))
    else $error("byte enables or data altered on the way to memory");

  a_read_return: assert property (
    (state_r == PDW_RDW) && mem_rdata_valid |=> pci_rdata_valid &&
      (pci_rdata == $past(mem_rdata)))
    else $error("read data not returned to the master");

  a_word_advance: assert property (
    (state_r == PDW_MEM) && mem_req_ready && cur_wr_r |=>
      cur_addr_r == {$past(cur_addr_r[31:2]), 2'b00} + 32'h4)
    else $error("burst address did not step one word");

  a_cmd_accept: assert property (
    (state_r == PDW_IDLE) && pci_addr_valid && !new_is_io && !new_is_mem |=> !pci_claim)
    else $error("unsupported command claimed");

endmodule : pdw_target
`default_nettype wire

// ===== pdw_mem_model.sv
// Memory bus responder standing behind the target block's forwarded requests
`timescale 1ns/1ps
`default_nettype none

module pdw_mem_model (
  // Clock and pacing
  input wire logic clock,
  input wire logic slow,
  // Request side
  input wire logic mem_req_valid,
  input wire logic mem_req_write,
  input wire logic [27:0] mem_req_addr,
  output logic mem_req_ready,
  // Read return
  output logic mem_rdata_valid,
  output logic [31:0] mem_rdata
);
  int cnt = 0;
  int rcnt = -1;
  logic was_rd = 1'b0;
  logic [27:0] raddr = 28'h0;

  initial begin
    mem_req_ready = 1'b0;
    mem_rdata_valid = 1'b0;
    mem_rdata = 32'h0;
  end

  // Note what was granted at the handshake edge
  always @(posedge clock) begin
    if (mem_req_valid && mem_req_ready) begin
      raddr <= mem_req_addr;
      was_rd <= !mem_req_write;
    end
  end

  // Grant after a pacing delay, then return read data a while later
  always @(negedge clock) begin
    mem_rdata_valid <= (rcnt == 0);
    // Idle data toggles so stale words never pass
    mem_rdata <= (rcnt == 0) ? {4'h5, raddr} : ~mem_rdata;
    if (mem_req_ready) begin
      mem_req_ready <= 1'b0;
      rcnt <= was_rd ? (slow ? 3 : 0) : -1;
    end else if (mem_req_valid) begin
      if (cnt >= (slow ? 2 : 0)) begin
        mem_req_ready <= 1'b1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
    if (rcnt >= 0) rcnt <= rcnt - 1;
  end
endmodule : pdw_mem_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the target window decode and translation block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] target_window_base [6];
  logic [4:0] target_window_size [6];
  logic [5:0] win_enable = 6'h1F;
  logic [5:0] win_is_io = 6'h03;
  logic tlb_acc_wr = 1'b0, tlb_acc_inval = 1'b0, tlb_acc_valid = 1'b0;
  logic [3:0] tlb_acc_idx = 4'h0;
  logic [19:0] tlb_acc_tag = 20'h0, tlb_rd_tag;
  logic [15:0] tlb_acc_data = 16'h0, tlb_rd_data;
  logic tlb_rd_valid, pci_claim, pci_data_ready, pci_rdata_valid, pci_stop, pci_abort;
  logic pci_addr_valid = 1'b0, pci_data_valid = 1'b0, pci_last = 1'b0, slow = 1'b0;
  logic [31:0] pci_addr = 32'h0, pci_wdata = 32'h0, pci_rdata, mem_req_wdata, mem_rdata;
  logic [3:0] pci_cmd = 4'h0, pci_be = 4'h0, mem_req_be, irq_level;
  logic pci_busy, mem_req_valid, mem_req_ready, mem_req_write, mem_rdata_valid, irq_miss;
  logic [27:0] mem_req_addr;
  int error_cnt = 0, compares = 0, seed = 68337;
  logic [64:0] mq [$];
  logic [31:0] rq [$];
  logic [19:0] tags [16];
  logic [15:0] phys [16];
  logic live [16];

  pdw_target dut_u (.clock, .sys_rst, .target_window_base, .target_window_size, .win_enable,
    .win_is_io, .tlb_acc_wr, .tlb_acc_inval, .tlb_acc_idx, .tlb_acc_tag, .tlb_acc_data,
    .tlb_acc_valid, .tlb_rd_tag, .tlb_rd_data, .tlb_rd_valid, .pci_addr_valid, .pci_addr,
    .pci_cmd, .pci_claim, .pci_data_valid, .pci_be, .pci_wdata, .pci_last, .pci_data_ready,
    .pci_rdata, .pci_rdata_valid, .pci_stop, .pci_abort, .pci_busy, .mem_req_valid,
    .mem_req_ready, .mem_req_write, .mem_req_addr, .mem_req_be, .mem_req_wdata,
    .mem_rdata_valid, .mem_rdata, .irq_miss, .irq_level);

  pdw_mem_model mem_u (.clock, .slow, .mem_req_valid, .mem_req_write, .mem_req_addr,
    .mem_req_ready, .mem_rdata_valid, .mem_rdata);

  // 200 MHz clock
  always #2.5 clock = ~clock;

  // ----------------------------------------------------------------------
  // Checking and verdict
  // ----------------------------------------------------------------------
  task automatic check(input string nm, input logic [71:0] seen, input logic [71:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Oldest note is matched against each memory request and read return
  always @(posedge clock) begin
    if (mem_req_valid && mem_req_ready) begin
      if (mq.size() == 0) check("mem_extra", 1, 0);
      else check("mem_req", {mem_req_write, mem_req_addr, mem_req_be,
        mem_req_write ? mem_req_wdata : 32'h0}, mq.pop_front());
    end
    if (pci_rdata_valid) begin
      if (rq.size() == 0) check("rd_extra", 1, 0);
      else check("rdata", pci_rdata, rq.pop_front());
    end
  end

  // Hang guard, well beyond the expected run length
  initial begin
    #300000;
    error_cnt++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------------
  // Lowest matching live entry wins, as the translation buffer resolves duplicates
  function automatic logic [27:0] xl(input logic [31:0] a);
    xl = 28'h0;
    for (int i = 15; i >= 0; i--) if (live[i] && tags[i] == a[31:12]) xl = {phys[i], a[11:2], 2'b00};
  endfunction : xl

  task automatic tlb_put(input int i, input logic [19:0] t);
    tlb_acc_idx = i[3:0];
    tlb_acc_tag = t;
    tlb_acc_data = 16'($random(seed));
    tlb_acc_valid = 1'b1;
    tlb_acc_wr = 1'b1;
    tags[i] = t;
    phys[i] = tlb_acc_data;
    live[i] = 1'b1;
    @(negedge clock) tlb_acc_wr = 1'b0;
    @(negedge clock);
  endtask : tlb_put

  // Readback shows one cycle after the index is presented
  task automatic tlb_chk(input int i);
    tlb_acc_idx = i[3:0];
    @(negedge clock);
    check("tlb_rd", {tlb_rd_valid, tlb_rd_tag, tlb_rd_data}, {live[i], tags[i], phys[i]});
  endtask : tlb_chk

  // fin: 0 normal end, 1 last phase expects a disconnect, 2 expects a miss abort
  task automatic xfer(input logic [3:0] c, input logic [31:0] a, input int n,
      input logic [3:0] fb, input logic [3:0] lb, input logic cl, input int fin);
    int k;
    logic [27:0] ma;
    slow = 1'($random(seed));
    pci_cmd = c;
    pci_addr = a;
    pci_addr_valid = 1'b1;
    @(negedge clock) pci_addr_valid = 1'b0;
    check("claim", pci_claim, cl);
    if (!cl) begin
      repeat (3) @(negedge clock);
      return;
    end
    for (int p = 0; p < n; p++) begin
      ma = xl(a + 32'(4 * p));
      pci_be = (p == 0) ? fb : (p == n - 1) ? lb : 4'hF;
      pci_wdata = $random(seed);
      pci_last = (p == n - 1);
      pci_data_valid = 1'b1;
      k = 0;
      if (fin != 0 && p == n - 1) begin
        @(negedge clock) pci_data_valid = 1'b0;
        check("term", {pci_stop, pci_abort, irq_miss}, fin == 1 ? 3'b100 : 3'b011);
        if (fin == 2) check("level", irq_level, 4'hF);
      end else begin
        check("ready", pci_data_ready, 1);
        mq.push_back({c[0], ma, pci_be, c[0] ? pci_wdata : 32'h0});
        if (!c[0]) rq.push_back({4'h5, ma});
        @(negedge clock) pci_data_valid = 1'b0;
        if (c[0]) while (mem_req_valid && k++ < 20) @(negedge clock);
        else while (!pci_rdata_valid && k++ < 40) @(negedge clock);
      end
    end
    k = 0;
    while (pci_busy && k++ < 20) @(negedge clock);
    check("idle", pci_busy, 0);
  endtask : xfer

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    int lens [6] = '{1, 1, 1, 2, 4, 8};
    logic [3:0] bes [6] = '{4'h4, 4'hC, 4'hF, 4'hF, 4'hF, 4'hF};
    logic [3:0] cmds [3] = '{4'hF, 4'hC, 4'hE};
    logic [3:0] fbe [3] = '{4'hE, 4'hC, 4'h8};
    logic [3:0] lbe [3] = '{4'h1, 4'h3, 4'h7};
    // Two adjacent 256-byte I/O windows, 4 KB and 1 GB memory, an oversize code, one off
    target_window_base = '{32'hF0001000, 32'hF0001100, 32'hD000A000, 32'h40000000,
      32'h80000000, 32'hC0000000};
    target_window_size = '{5'd0, 5'd0, 5'd4, 5'd22, 5'd23, 5'd0};
    win_enable = 6'h1F;
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    for (int i = 0; i < 16; i++) tlb_put(i, i == 0 ? 20'hF0001 : i == 1 ? 20'hD000A : 20'h40000 + i);
    for (int i = 0; i < 16; i++) tlb_chk(i);
    // Each entry translates a write and a read of the same word
    for (int i = 0; i < 16; i++) begin
      k_loop: for (int d = 1; d >= 0; d--) begin
        xfer((i == 0 ? 4'h2 : 4'h6) + 4'(d), {tags[i], 12'h0} + 32'(i * 8), 1, 4'hF, 4'hF, 1, 0);
      end
    end
    // Access sizes in the I/O and the memory window
    for (int w = 0; w < 2; w++) begin
      for (int s = 0; s < 6; s++) begin
        for (int d = 1; d >= 0; d--) begin
          xfer((w == 0 ? 4'h2 : 4'h6) + 4'(d), w == 0 ? 32'hF0001000 : 32'hD000A100,
            lens[s], bes[s], bes[s], 1, 0);
        end
      end
    end
    // Line commands with partial first and last words
    for (int c = 0; c < 3; c++) begin
      for (int l = 0; l < 3; l++) xfer(cmds[c], 32'hD000A200, 4 * (l + 1), fbe[(c + l) % 3],
        lbe[l], 1, 0);
    end
    xfer(4'h3, 32'hF0001000, 65, 4'hF, 4'hF, 1, 0);
    xfer(4'h3, 32'hD000A000, 1, 4'hF, 4'hF, 0, 0);
    xfer(4'h7, 32'hF0001000, 1, 4'hF, 4'hF, 0, 0);
    xfer(4'h1, 32'hD000A000, 1, 4'hF, 4'hF, 0, 0);
    xfer(4'h7, 32'h30000000, 1, 4'hF, 4'hF, 0, 0);
    xfer(4'h7, 32'h80000000, 1, 4'hF, 4'hF, 0, 0);
    xfer(4'h7, 32'hC0000000, 1, 4'hF, 4'hF, 0, 0);
    xfer(4'h2, 32'hF0001200, 1, 4'hF, 4'hF, 0, 0);
    xfer(4'h7, 32'hD000AFF8, 3, 4'hF, 4'hF, 1, 1);
    // Flush one entry; its neighbour keeps translating
    tlb_acc_idx = 4'h5;
    tlb_acc_inval = 1'b1;
    live[5] = 1'b0;
    @(negedge clock) tlb_acc_inval = 1'b0;
    tlb_chk(5);
    tlb_chk(6);
    xfer(4'h7, 32'h40005000, 1, 4'hF, 4'hF, 1, 2);
    xfer(4'h7, 32'h7FFFF000, 1, 4'hF, 4'hF, 1, 2);
    xfer(4'h7, 32'h40006000, 1, 4'hF, 4'hF, 1, 0);
    check("level", irq_level, 4'h0);
    check("left", mq.size() + rq.size(), 0);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
